// ===== shared/return_rotate_sleep_pkg.sv
// shared constants and types for the return, rotate and sleep execution block
package return_rotate_sleep_pkg;

    // ==========================================================
    // sizes
    localparam int DATA_W = 8;
    localparam int FILE_DEPTH = 128;
    localparam int FILE_ADDR_W = 7;
    localparam int PC_W = 13;
    localparam int STACK_DEPTH = 8;
    localparam int STACK_PTR_W = 3;
    localparam int BUS_ADDR_W = 8;

    // ==========================================================
    // register port map
    localparam logic [7:0] ADDR_FILE_LAST = 8'h7F;
    localparam logic [7:0] ADDR_WORK = 8'h80;
    localparam logic [7:0] ADDR_STATUS = 8'h81;
    localparam logic [7:0] ADDR_PC_LO = 8'h82;
    localparam logic [7:0] ADDR_PC_HI = 8'h83;
    localparam logic [7:0] ADDR_STACK_PTR = 8'h84;
    localparam logic [7:0] ADDR_CONTROL = 8'h85;

    // ==========================================================
    // field positions
    localparam int STATUS_CARRY_BIT = 0;
    localparam int STATUS_POWERDOWN_BIT = 3;
    localparam int STATUS_TIMEOUT_BIT = 4;
    localparam int CTRL_SLEEPING_BIT = 0;
    localparam int CTRL_OSC_STOP_BIT = 1;
    localparam int CTRL_READY_BIT = 2;
    localparam int CTRL_WAKE_BIT = 0;

    // ==========================================================
    // reset values
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic [7:0] FILE_RST = 8'h00;
    localparam logic [12:0] PC_RST = 13'h0000;
    localparam logic [12:0] STACK_RST = 13'h0000;
    localparam logic [2:0] STACK_PTR_RST = 3'h0;
    localparam logic CARRY_RST = 1'b0;
    localparam logic TIMEOUT_RST = 1'b1;
    localparam logic POWERDOWN_RST = 1'b1;

    // ==========================================================
    // timing and operand encodings
    localparam int RETURN_CYCLES = 2;
    localparam int ROTATE_CYCLES = 1;
    localparam logic DEST_WORK = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    typedef enum logic [2:0]
    {
        OP_NONE = 3'b000,
        OP_RETURN = 3'b001,
        OP_ROTATE_LEFT = 3'b010,
        OP_ROTATE_RIGHT = 3'b011,
        OP_SLEEP = 3'b100
    } exec_op_t;

    typedef enum logic [1:0]
    {
        ST_READY = 2'b00,
        ST_RETURN_FLUSH = 2'b01,
        ST_SLEEP = 2'b10
    } exec_state_t;

endpackage

// ===== core/rotate_carry_unit.sv
// one-bit rotate through carry, left or right
`timescale 1ns/100ps
module rotate_carry_unit
    import return_rotate_sleep_pkg::*;
#(
    parameter int WIDTH = DATA_W
)
(
    // operand
    input wire logic [WIDTH-1:0] operand,
    input wire logic carry_in,
    input wire logic rotate_left,
    // result
    output logic [WIDTH-1:0] result,
    output logic carry_out
);

    // ==========================================================
    // per-bit source selection
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            if (i == 0)
            begin : g_low
                assign result[i] = rotate_left ? carry_in : operand[i+1];
            end
            else if (i == WIDTH - 1)
            begin : g_high
                assign result[i] = rotate_left ? operand[i-1] : carry_in;
            end
            else
            begin : g_mid
                assign result[i] = rotate_left ? operand[i-1] : operand[i+1];
            end
        end
    endgenerate

    // the bit pushed out becomes the new carry
    assign carry_out = rotate_left ? operand[WIDTH-1] : operand[0];

endmodule

// ===== core/return_rotate_sleep_exec.sv
// execution of subroutine return, rotate through carry and sleep
// Operation
// - A subroutine return pops the stack and loads the popped top value into the program counter.
// - A subroutine return takes two instruction cycles and changes no status flag.
// - Rotate left moves each file register bit up one place, old carry into bit zero, old top bit into carry.
// - Rotate operands are a seven-bit file address from 0 to 127 and a one-bit destination select.
// - Rotate left writes its result to the working register for select 0 and to the file register for 1.
// - Rotate right moves each bit down one place, old carry into the top bit, old bit zero into carry.
// - Rotate right writes its result to the working register for select 0 and to the file register for 1.
// - Sleep clears the watchdog count and the watchdog prescaler.
// - Sleep clears the power-down flag and sets the time-out flag.
// - After sleep the core halts in its low-power state with the oscillator stopped.
`timescale 1ns/100ps
module return_rotate_sleep_exec
    import return_rotate_sleep_pkg::*;
#(
    parameter int DEPTH = FILE_DEPTH,
    parameter int STACK_ENTRIES = STACK_DEPTH
)
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // decoded instruction from fetch
    input wire logic op_valid,
    input wire exec_op_t op_code,
    input wire logic [FILE_ADDR_W-1:0] op_file,
    input wire logic op_dest,
    output logic op_ready,
    output logic op_retired,
    // stack push from the call path
    input wire logic push_valid,
    input wire logic [PC_W-1:0] push_addr,
    // program counter
    output logic [PC_W-1:0] pc,
    // watchdog and oscillator control
    output logic watchdog_count_clear,
    output logic prescaler_clear,
    output logic sleeping,
    output logic osc_stop,
    input wire logic wake_event,
    // register port
    input wire logic [BUS_ADDR_W-1:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [DATA_W-1:0] bus_rdata
);

    // ==========================================================
    // state
    typedef struct packed
    {
        exec_state_t state;
        logic [DEPTH-1:0][DATA_W-1:0] file_reg;
        logic [DATA_W-1:0] work;
        logic carry;
        logic timeout_flag;
        logic powerdown_flag;
        logic [PC_W-1:0] pc;
        logic [STACK_ENTRIES-1:0][PC_W-1:0] stack;
        logic [STACK_PTR_W-1:0] stack_ptr;
        logic ready;
        logic retired;
        logic sleeping;
        logic osc_stop;
        logic watchdog_clear;
        logic prescaler_clear;
        logic [DATA_W-1:0] rdata;
    } exec_regs_t;

    exec_regs_t r;
    exec_regs_t next_r;

    logic [PC_W-1:0] stack_top;
    logic [STACK_PTR_W-1:0] pop_ptr;
    logic [DATA_W-1:0] rot_operand;
    logic [DATA_W-1:0] rot_result;
    logic rot_carry;
    logic rot_left;
    logic wake;
    logic sel_file;
    logic sel_work;
    logic sel_status;
    logic sel_pc_lo;
    logic sel_pc_hi;
    logic sel_stack_ptr;
    logic sel_control;

    // ==========================================================
    // rotate datapath
    assign rot_operand = r.file_reg[op_file];
    assign rot_left = (op_code == OP_ROTATE_LEFT);

    rotate_carry_unit #(
        .WIDTH(DATA_W)
    ) u_rotate (
        .operand(rot_operand),
        .carry_in(r.carry),
        .rotate_left(rot_left),
        .result(rot_result),
        .carry_out(rot_carry)
    );

    // the stack is circular: the pointer wraps, as in a small hardware stack
    assign pop_ptr = r.stack_ptr - 3'h1;
    assign stack_top = r.stack[pop_ptr];

    // ==========================================================
    // register port address decode
    always_comb
    begin
        sel_file = 1'b0;
        sel_work = 1'b0;
        sel_status = 1'b0;
        sel_pc_lo = 1'b0;
        sel_pc_hi = 1'b0;
        sel_stack_ptr = 1'b0;
        sel_control = 1'b0;
        if (bus_addr <= ADDR_FILE_LAST)
        begin
            sel_file = 1'b1;
        end
        else if (bus_addr == ADDR_WORK)
        begin
            sel_work = 1'b1;
        end
        else if (bus_addr == ADDR_STATUS)
        begin
            sel_status = 1'b1;
        end
        else if (bus_addr == ADDR_PC_LO)
        begin
            sel_pc_lo = 1'b1;
        end
        else if (bus_addr == ADDR_PC_HI)
        begin
            sel_pc_hi = 1'b1;
        end
        else if (bus_addr == ADDR_STACK_PTR)
        begin
            sel_stack_ptr = 1'b1;
        end
        else if (bus_addr == ADDR_CONTROL)
        begin
            sel_control = 1'b1;
        end
    end

    // wake from a pin event or from software through the control register
    assign wake = wake_event | (bus_wr && sel_control && bus_wdata[CTRL_WAKE_BIT]);

    // ==========================================================
    // next state
    always_comb
    begin
        next_r = r;
        next_r.rdata = '0;
        next_r.retired = 1'b0;
        next_r.watchdog_clear = 1'b0;
        next_r.prescaler_clear = 1'b0;

        // software writes first, so that a same-cycle instruction result wins
        if (bus_wr)
        begin
            if (sel_file)
            begin
                next_r.file_reg[bus_addr[FILE_ADDR_W-1:0]] = bus_wdata;
            end
            else if (sel_work)
            begin
                next_r.work = bus_wdata;
            end
            else if (sel_status)
            begin
                // time-out and power-down are read only
                next_r.carry = bus_wdata[STATUS_CARRY_BIT];
            end
            else if (sel_pc_lo)
            begin
                next_r.pc[DATA_W-1:0] = bus_wdata;
            end
            else if (sel_pc_hi)
            begin
                next_r.pc[PC_W-1:DATA_W] = bus_wdata[PC_W-DATA_W-1:0];
            end
        end

        // reads show the state before this cycle's update
        if (bus_rd)
        begin
            if (sel_file)
            begin
                next_r.rdata = r.file_reg[bus_addr[FILE_ADDR_W-1:0]];
            end
            else if (sel_work)
            begin
                next_r.rdata = r.work;
            end
            else if (sel_status)
            begin
                next_r.rdata[STATUS_CARRY_BIT] = r.carry;
                next_r.rdata[STATUS_POWERDOWN_BIT] = r.powerdown_flag;
                next_r.rdata[STATUS_TIMEOUT_BIT] = r.timeout_flag;
            end
            else if (sel_pc_lo)
            begin
                next_r.rdata = r.pc[DATA_W-1:0];
            end
            else if (sel_pc_hi)
            begin
                next_r.rdata[PC_W-DATA_W-1:0] = r.pc[PC_W-1:DATA_W];
            end
            else if (sel_stack_ptr)
            begin
                next_r.rdata[STACK_PTR_W-1:0] = r.stack_ptr;
            end
            else if (sel_control)
            begin
                next_r.rdata[CTRL_SLEEPING_BIT] = r.sleeping;
                next_r.rdata[CTRL_OSC_STOP_BIT] = r.osc_stop;
                next_r.rdata[CTRL_READY_BIT] = r.ready;
            end
        end

        case (r.state)
            ST_READY:
            begin
                if (op_valid)
                begin
                    case (op_code)
                        OP_RETURN:
                        begin
                            // pop and load; no status bit is touched
                            next_r.pc = stack_top;
                            next_r.stack_ptr = pop_ptr;
                            next_r.state = ST_RETURN_FLUSH;
                            next_r.ready = 1'b0;
                        end
                        OP_ROTATE_LEFT:
                        begin
                            if (op_dest == DEST_FILE)
                            begin
                                next_r.file_reg[op_file] = rot_result;
                            end
                            else
                            begin
                                next_r.work = rot_result;
                            end
                            next_r.carry = rot_carry;
                            next_r.retired = 1'b1;
                        end
                        OP_ROTATE_RIGHT:
                        begin
                            if (op_dest == DEST_FILE)
                            begin
                                next_r.file_reg[op_file] = rot_result;
                            end
                            else
                            begin
                                next_r.work = rot_result;
                            end
                            next_r.carry = rot_carry;
                            next_r.retired = 1'b1;
                        end
                        OP_SLEEP:
                        begin
                            next_r.watchdog_clear = 1'b1;
                            next_r.prescaler_clear = 1'b1;
                            next_r.powerdown_flag = 1'b0;
                            next_r.timeout_flag = 1'b1;
                            next_r.sleeping = 1'b1;
                            next_r.osc_stop = 1'b1;
                            next_r.ready = 1'b0;
                            next_r.retired = 1'b1;
                            next_r.state = ST_SLEEP;
                            // work, file registers and carry stay as they are
                        end
                        default:
                        begin
                            next_r.state = ST_READY;
                        end
                    endcase
                end
                else if (push_valid)
                begin
                    // any valid instruction in the same cycle wins; the call path never overlaps it
                    next_r.stack[r.stack_ptr] = push_addr;
                    next_r.stack_ptr = r.stack_ptr + 3'h1;
                end
            end
            ST_RETURN_FLUSH:
            begin
                // second cycle of the return: the fetched word is discarded
                next_r.state = ST_READY;
                next_r.ready = 1'b1;
                next_r.retired = 1'b1;
            end
            ST_SLEEP:
            begin
                // halted: instructions and pushes are ignored until a wake
                if (wake)
                begin
                    next_r.state = ST_READY;
                    next_r.sleeping = 1'b0;
                    next_r.osc_stop = 1'b0;
                    next_r.ready = 1'b1;
                end
            end
            default:
            begin
                next_r.state = ST_READY;
                next_r.ready = 1'b1;
            end
        endcase
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            r.state <= ST_READY;
            r.file_reg <= {DEPTH{FILE_RST}};
            r.work <= WORK_RST;
            r.carry <= CARRY_RST;
            r.timeout_flag <= TIMEOUT_RST;
            r.powerdown_flag <= POWERDOWN_RST;
            r.pc <= PC_RST;
            r.stack <= {STACK_ENTRIES{STACK_RST}};
            r.stack_ptr <= STACK_PTR_RST;
            r.ready <= 1'b1;
            r.retired <= 1'b0;
            r.sleeping <= 1'b0;
            r.osc_stop <= 1'b0;
            r.watchdog_clear <= 1'b0;
            r.prescaler_clear <= 1'b0;
            r.rdata <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ==========================================================
    // outputs
    assign op_ready = r.ready;
    assign op_retired = r.retired;
    assign pc = r.pc;
    assign watchdog_count_clear = r.watchdog_clear;
    assign prescaler_clear = r.prescaler_clear;
    assign sleeping = r.sleeping;
    assign osc_stop = r.osc_stop;
    assign bus_rdata = r.rdata;

endmodule

// ===== verification/return_rotate_sleep_exec_checker.sv
// port assertions for the return, rotate and sleep execution block
`timescale 1ns/100ps
module return_rotate_sleep_exec_checker
    import return_rotate_sleep_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // instruction port
    input wire logic op_valid,
    input wire exec_op_t op_code,
    input wire logic op_ready,
    input wire logic op_retired,
    // watchdog and oscillator control
    input wire logic watchdog_count_clear,
    input wire logic prescaler_clear,
    input wire logic sleeping,
    input wire logic osc_stop,
    input wire logic wake_event,
    input wire logic bus_wr
);
    // ==========================================================
    // sequences
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);
    logic take;
    assign take = op_valid && op_ready;
    sequence s_ret_take;
        take && op_code == OP_RETURN;
    endsequence
    sequence s_ret_done;
        !op_ready && !op_retired ##1 op_ready && op_retired;
    endsequence
    sequence s_rot_take;
        take && (op_code == OP_ROTATE_LEFT || op_code == OP_ROTATE_RIGHT);
    endsequence
    sequence s_slp_take;
        take && op_code == OP_SLEEP;
    endsequence
    // ==========================================================
    // assertions
    a_return_two_cycles: assert property (s_ret_take |=> s_ret_done)
        else $error("return did not retire on its second cycle");
    a_rotate_one_cycle: assert property (s_rot_take |=> op_retired && op_ready)
        else $error("rotate did not retire in one cycle");
    a_sleep_clears_watchdog: assert property (s_slp_take |=>
        watchdog_count_clear && prescaler_clear ##1 !watchdog_count_clear && !prescaler_clear)
        else $error("sleep did not pulse the watchdog clears once");
    a_clears_paired: assert property (watchdog_count_clear == prescaler_clear)
        else $error("watchdog clears out of step");
    a_clear_needs_sleep: assert property ($rose(watchdog_count_clear) |->
        $past(take) && $past(op_code) == OP_SLEEP)
        else $error("watchdog clear without sleep");
    a_sleep_halts_core: assert property (s_slp_take |=>
        sleeping && osc_stop && !op_ready && op_retired)
        else $error("sleep did not halt the core");
    a_osc_with_sleep: assert property (osc_stop == sleeping)
        else $error("oscillator stop differs from sleep state");
    a_sleep_holds_on: assert property (sleeping && !wake_event && !bus_wr |=> sleeping)
        else $error("sleep left without a wake");
    a_wake_ends_sleep: assert property (sleeping && wake_event |=> !sleeping && op_ready)
        else $error("wake did not end sleep");
endmodule

// ===== verification/tb_top.sv
// self-checking bench for the return, rotate and sleep execution block
`timescale 1ns/100ps
module tb_top;
    import return_rotate_sleep_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic op_valid = 1'b0;
    exec_op_t op_code = OP_NONE;
    logic [6:0] op_file = 7'h00;
    logic op_dest = 1'b0;
    logic push_valid = 1'b0;
    logic [12:0] push_addr = 13'h0000;
    logic wake_event = 1'b0;
    logic [7:0] bus_addr = 8'h00;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic op_ready, op_retired, watchdog_count_clear, prescaler_clear, sleeping, osc_stop;
    logic [12:0] pc;
    logic [7:0] bus_rdata;
    logic [7:0] rv;
    logic carry = 1'b0;
    logic [7:0] work = 8'h00;
    int err_count = 0;
    int num_checks = 0;

    return_rotate_sleep_exec u_return_rotate_sleep_exec (.clk, .resetn, .op_valid, .op_code,
        .op_file, .op_dest, .op_ready, .op_retired, .push_valid, .push_addr, .pc,
        .watchdog_count_clear, .prescaler_clear, .sleeping, .osc_stop, .wake_event,
        .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata);

    initial forever #2.5 clk = ~clk;

    // ==========================================================
    // access tasks
    task automatic chk(input string name, input logic [12:0] seen, input logic [12:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one idle cycle after each strobe so back-to-back calls never reassign it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        @(posedge clk);
        rv = bus_rdata;
    endtask
    // keep holds valid so the next call issues on the following edge
    task automatic run_op(input exec_op_t c, input logic [6:0] f, input logic d, input logic keep);
        op_valid <= 1'b1;
        op_code <= c;
        op_file <= f;
        op_dest <= d;
        @(posedge clk);
        if (!keep)
        begin
            op_valid <= 1'b0;
            @(posedge clk);
        end
    endtask
    task automatic push(input logic [12:0] v);
        push_valid <= 1'b1;
        push_addr <= v;
        @(posedge clk);
        push_valid <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rot(input exec_op_t c, input logic [6:0] a, input logic d, input logic [7:0] v);
        logic [7:0] res;
        logic nc;
        wr({1'b0, a}, v);
        if (c == OP_ROTATE_LEFT)
            {nc, res} = {v, carry};
        else
            {res, nc} = {carry, v};
        run_op(c, a, d, 1'b0);
        chk("retired", 13'(op_retired), 13'h0001);
        rd(ADDR_WORK);
        chk("work", 13'(rv), 13'(d ? work : res));
        rd({1'b0, a});
        chk("file", 13'(rv), 13'(d ? res : v));
        rd(ADDR_STATUS);
        chk("status", 13'(rv & 8'h19), 13'({7'h0C, nc}));
        carry = nc;
        if (!d)
            work = res;
    endtask
    task automatic give_verdict();
        if (err_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ==========================================================
    // tests
    initial
    begin
        #50000;
        err_count++;
        give_verdict();
    end
    initial
    begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        rot(OP_ROTATE_LEFT, 7'h05, 1'b0, 8'hE6);
        rot(OP_ROTATE_LEFT, 7'h7F, 1'b1, 8'h81);
        rot(OP_ROTATE_RIGHT, 7'h00, 1'b0, 8'h01);
        rot(OP_ROTATE_RIGHT, 7'h40, 1'b1, 8'h02);
        run_op(OP_NONE, 7'h05, 1'b0, 1'b0);
        chk("none", 13'(op_retired), 13'h0000);
        wr(8'h22, 8'h3C);
        run_op(OP_ROTATE_LEFT, 7'h22, 1'b1, 1'b1);
        run_op(OP_ROTATE_RIGHT, 7'h22, 1'b1, 1'b0);
        rd(8'h22);
        chk("back to back", 13'(rv), 13'h003C);
        push(13'h1ABC);
        push(13'h0123);
        rd(ADDR_STACK_PTR);
        chk("depth", 13'(rv & 8'h07), 13'h0002);
        // carry set so that a return that disturbed the status would show
        wr(ADDR_STATUS, 8'h01);
        run_op(OP_RETURN, 7'h00, 1'b0, 1'b0);
        chk("pc", pc, 13'h0123);
        chk("ready", 13'(op_ready), 13'h0000);
        @(posedge clk);
        chk("retired", 13'({op_retired, op_ready}), 13'h0003);
        run_op(OP_RETURN, 7'h00, 1'b0, 1'b0);
        chk("pc", pc, 13'h1ABC);
        @(posedge clk);
        rd(ADDR_STATUS);
        chk("status", 13'(rv & 8'h19), 13'h0019);
        rd(ADDR_STACK_PTR);
        chk("depth", 13'(rv & 8'h07), 13'h0000);
        wr(ADDR_PC_LO, 8'h34);
        wr(ADDR_PC_HI, 8'hF2);
        chk("pc", pc, 13'h1234);
        rd(ADDR_PC_HI);
        chk("pc high", 13'(rv), 13'h0012);
        wr(ADDR_WORK, 8'h5A);
        wr(ADDR_STATUS, 8'h01);
        run_op(OP_SLEEP, 7'h00, 1'b0, 1'b0);
        chk("sleep", 13'({sleeping, osc_stop, watchdog_count_clear, prescaler_clear}), 13'h000F);
        @(posedge clk);
        chk("clears", 13'({watchdog_count_clear, prescaler_clear}), 13'h0000);
        run_op(OP_ROTATE_LEFT, 7'h05, 1'b0, 1'b0);
        rd(ADDR_STATUS);
        chk("status", 13'(rv & 8'h19), 13'h0011);
        rd(ADDR_WORK);
        chk("work", 13'(rv), 13'h005A);
        rd(8'h05);
        chk("file", 13'(rv), 13'h00E6);
        rd(ADDR_CONTROL);
        chk("control", 13'(rv & 8'h07), 13'h0003);
        wake_event <= 1'b1;
        @(posedge clk);
        wake_event <= 1'b0;
        @(posedge clk);
        chk("awake", 13'({sleeping, osc_stop, op_ready}), 13'h0001);
        run_op(OP_SLEEP, 7'h00, 1'b0, 1'b0);
        chk("asleep", 13'(sleeping), 13'h0001);
        wr(ADDR_CONTROL, 8'h01);
        chk("awake", 13'(sleeping), 13'h0000);
        rd(8'h90);
        chk("unmapped", 13'(rv), 13'h0000);
        give_verdict();
    end
endmodule

bind return_rotate_sleep_exec return_rotate_sleep_exec_checker u_return_rotate_sleep_exec_checker (
    .clk, .resetn, .op_valid, .op_code, .op_ready, .op_retired, .watchdog_count_clear,
    .prescaler_clear, .sleeping, .osc_stop, .wake_event, .bus_wr);
